// ==== hdl/vpt_pkg.sv ====
package vpt_pkg;
  // register offsets, byte addresses on the plain register port
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PROG_BASE = 8'h04;
  localparam logic [7:0] OFS_PROG_LEN = 8'h08;
  localparam logic [7:0] OFS_CTL_BASE = 8'h0C;
  localparam logic [7:0] OFS_CTL_LEN = 8'h10;
  localparam logic [7:0] OFS_SYS_BASE = 8'h14;
  localparam logic [7:0] OFS_SYS_LEN = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_TABLE0 = 8'h20;
  localparam int unsigned TABLE_WORDS = 4;
  // control and status field positions
  localparam int unsigned CTRL_MAP_EN = 0;
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_FAULT_LO = 1;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [21:0] RST_LEN = 22'h00_0000;
  // virtual address layout
  localparam int unsigned VA_SYS_BIT = 31;
  localparam int unsigned VA_CTL_BIT = 30;
  localparam int unsigned OFS_W = 9;
  localparam int unsigned IDX_W = 22;
  // page map entry layout
  localparam int unsigned PTE_VALID = 31;
  localparam int unsigned PTE_CODE_LO = 27;
  localparam int unsigned PTE_WRITTEN = 26;
  localparam int unsigned PTE_RSVD = 25;
  localparam int unsigned PFN_W = 21;
  localparam int unsigned PA_W = 30;
  // mode used for fetching process map entries
  localparam logic [1:0] MODE_KERNEL = 2'h0;

  typedef enum logic [2:0] {
    KIND_READ, KIND_WRITE, KIND_MODIFY, KIND_PROBE_RD, KIND_PROBE_WR
  } vpt_kind_t;

  typedef enum logic [1:0] {
    FAULT_NONE, FAULT_ACCESS, FAULT_INVALID
  } vpt_fault_t;

  typedef struct packed {
    logic [31:0] va;
    vpt_kind_t kind;
    logic [1:0] mode;
  } vpt_req_t;

  typedef struct packed {
    vpt_fault_t fault;
    logic [PA_W-1:0] pa;
  } vpt_resp_t;
endpackage : vpt_pkg

// ==== hdl/vpt_translate.sv ====
// Implementation choices: the plain strobed port and the address map.
module vpt_translate (
  input wire logic clock_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // translation request and answer
  input wire logic req_valid_i,
  input vpt_pkg::vpt_req_t req_i,
  output logic req_ready_o,
  output logic resp_valid_o,
  output vpt_pkg::vpt_resp_t resp_o,
  // page map memory port
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [vpt_pkg::PA_W-1:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i
);
  import vpt_pkg::*;

  // access code decode: one byte per code, low nibble read, high write
  function automatic logic code_ok(input logic [127:0] tbl,
                                   input logic [3:0] code,
                                   input logic [1:0] mode,
                                   input logic wr);
    logic [7:0] ent;
    ent = tbl[{code, 3'h0} +: 8];
    code_ok = wr ? ent[{1'b1, mode}] : ent[{1'b0, mode}];
  endfunction : code_ok

  typedef enum logic [1:0] {
    S_IDLE, S_SYS_RD, S_PTE_RD, S_MARK
  } vpt_state_t;

  // software visible state
  logic map_en_r;  // mapping enable bit
  logic [31:0] prog_base_r;  // system virtual address of program map
  logic [31:0] ctl_base_r;  // system virtual address of control map
  logic [31:0] sys_base_r;  // physical address of system map
  logic [IDX_W-1:0] prog_len_r;
  logic [IDX_W-1:0] ctl_len_r;
  logic [IDX_W-1:0] sys_len_r;
  logic [31:0] tbl_r [TABLE_WORDS];  // access code decode table
  logic [127:0] tbl_flat;
  logic [31:0] rd_mux;
  logic [31:0] rdata_r;
  vpt_fault_t last_fault_r;  // fault of the latest answer

  // translation state
  vpt_state_t state_r, state_nxt;
  vpt_req_t req_r, req_nxt;  // held request
  logic [PA_W-1:0] addr_r, addr_nxt;  // physical address to fetch
  logic [31:0] sva_r, sva_nxt;  // system address of process entry
  logic [31:0] entry_r, entry_nxt;  // entry to write back
  vpt_resp_t resp_r, resp_nxt;
  logic resp_valid_r, resp_valid_nxt;

  // register write decode, one word per table register
  wire reg_wr_ctrl = reg_wr_i && (reg_addr_i == OFS_CTRL);
  genvar gi;
  generate
    for (gi = 0; gi < TABLE_WORDS; gi++)
    begin : g_tbl
      wire tbl_hit = reg_wr_i &&
        (reg_addr_i == OFS_TABLE0 + 8'(gi * 4));
      // table word written whole, no byte lanes on this port
      always_ff @(posedge clock_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          tbl_r[gi] <= RST_WORD;
        else if (tbl_hit)
          tbl_r[gi] <= reg_wdata_i;
      end
      assign tbl_flat[gi*32 +: 32] = tbl_r[gi];
    end
  endgenerate

  // region, length and base registers; a process switch rewrites the
  // program and control pairs only
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      map_en_r <= 1'b0;
      prog_base_r <= RST_WORD;
      ctl_base_r <= RST_WORD;
      sys_base_r <= RST_WORD;
      prog_len_r <= RST_LEN;
      ctl_len_r <= RST_LEN;
      sys_len_r <= RST_LEN;
    end
    else if (reg_wr_i)
    begin
      if (reg_wr_ctrl)
        map_en_r <= reg_wdata_i[CTRL_MAP_EN];
      if (reg_addr_i == OFS_PROG_BASE)
        prog_base_r <= reg_wdata_i;
      if (reg_addr_i == OFS_CTL_BASE)
        ctl_base_r <= reg_wdata_i;
      if (reg_addr_i == OFS_SYS_BASE)
        sys_base_r <= reg_wdata_i;
      if (reg_addr_i == OFS_PROG_LEN)
        prog_len_r <= reg_wdata_i[IDX_W-1:0];
      if (reg_addr_i == OFS_CTL_LEN)
        ctl_len_r <= reg_wdata_i[IDX_W-1:0];
      if (reg_addr_i == OFS_SYS_LEN)
        sys_len_r <= reg_wdata_i[IDX_W-1:0];
    end
  end

  // read selection; unmapped offsets read as zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (reg_addr_i)
      OFS_CTRL: rd_mux[CTRL_MAP_EN] = map_en_r;
      OFS_PROG_BASE: rd_mux = prog_base_r;
      OFS_CTL_BASE: rd_mux = ctl_base_r;
      OFS_SYS_BASE: rd_mux = sys_base_r;
      OFS_PROG_LEN: rd_mux = 32'(prog_len_r);
      OFS_CTL_LEN: rd_mux = 32'(ctl_len_r);
      OFS_SYS_LEN: rd_mux = 32'(sys_len_r);
      OFS_STATUS:
      begin
        rd_mux[STAT_BUSY] = (state_r != S_IDLE);
        rd_mux[STAT_FAULT_LO +: 2] = last_fault_r;
      end
      OFS_TABLE0 + 8'h00: rd_mux = tbl_r[0];
      OFS_TABLE0 + 8'h04: rd_mux = tbl_r[1];
      OFS_TABLE0 + 8'h08: rd_mux = tbl_r[2];
      OFS_TABLE0 + 8'h0C: rd_mux = tbl_r[3];
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_r <= RST_WORD;
    else
      rdata_r <= reg_rd_i ? rd_mux : 32'h0000_0000;
  end
  assign reg_rdata_o = rdata_r;

  // request decode, looked at only while idle
  wire in_sys = req_i.va[VA_SYS_BIT];
  wire in_ctl = req_i.va[VA_CTL_BIT];
  // system half indexes with bit 30 too, so its limit covers it
  wire [IDX_W-1:0] pg_idx = in_sys ? req_i.va[30:OFS_W]
                                   : {1'b0, req_i.va[29:OFS_W]};
  wire [IDX_W-1:0] lim = in_sys ? sys_len_r
                                : (in_ctl ? ctl_len_r : prog_len_r);
  wire in_limit = (pg_idx < lim);
  wire [31:0] proc_base = in_ctl ? ctl_base_r : prog_base_r;
  // process entries sit in system space at base + 4 * index
  wire [31:0] sva = proc_base + 32'({pg_idx, 2'b00});
  wire sva_ok = sva[VA_SYS_BIT] && (sva[30:OFS_W] < sys_len_r);
  wire [PA_W-1:0] sys_pte = sys_base_r[PA_W-1:0] +
                            PA_W'({pg_idx, 2'b00});
  wire [PA_W-1:0] sva_pte = sys_base_r[PA_W-1:0] +
                            PA_W'({sva[30:OFS_W], 2'b00});
  // modify and probe-write are checked as write
  wire intent_wr = (req_r.kind != KIND_READ) &&
                   (req_r.kind != KIND_PROBE_RD);
  // fields of the entry returned by memory
  wire [3:0] ent_code = mem_rdata_i[PTE_CODE_LO +: 4];
  wire ent_valid = mem_rdata_i[PTE_VALID];
  wire ent_written = mem_rdata_i[PTE_WRITTEN];
  wire [PFN_W-1:0] ent_pfn = mem_rdata_i[PFN_W-1:0];
  wire sys_ent_ok = code_ok(tbl_flat, ent_code, MODE_KERNEL, 1'b0);
  wire pte_ok = code_ok(tbl_flat, ent_code, req_r.mode, intent_wr);

  // translation sequence
  always_comb
  begin
    state_nxt = state_r;
    req_nxt = req_r;
    addr_nxt = addr_r;
    sva_nxt = sva_r;
    entry_nxt = entry_r;
    resp_nxt = resp_r;
    resp_valid_nxt = 1'b0;
    case (state_r)
      S_IDLE:
        if (req_valid_i)
        begin
          req_nxt = req_i;
          sva_nxt = sva;
          if (!map_en_r)
          begin
            // no mapping: address passes straight through
            resp_nxt = '{FAULT_NONE, req_i.va[PA_W-1:0]};
            resp_valid_nxt = 1'b1;
          end
          else if (!in_limit || (!in_sys && !sva_ok))
          begin
            resp_nxt = '{FAULT_ACCESS, '0};
            resp_valid_nxt = 1'b1;
          end
          else if (in_sys)
          begin
            addr_nxt = sys_pte;
            state_nxt = S_PTE_RD;
          end
          else
          begin
            addr_nxt = sva_pte;
            state_nxt = S_SYS_RD;
          end
        end
      S_SYS_RD:
        if (mem_ack_i)
        begin
          // entry of the process map page, checked as kernel read
          if (!sys_ent_ok)
          begin
            resp_nxt = '{FAULT_ACCESS, '0};
            resp_valid_nxt = 1'b1;
            state_nxt = S_IDLE;
          end
          else if (!ent_valid)
          begin
            resp_nxt = '{FAULT_INVALID, '0};
            resp_valid_nxt = 1'b1;
            state_nxt = S_IDLE;
          end
          else
          begin
            addr_nxt = {ent_pfn, sva_r[OFS_W-1:0]};
            state_nxt = S_PTE_RD;
          end
        end
      S_PTE_RD:
        if (mem_ack_i)
        begin
          // rights first, so an invalid page still reports protection
          if (!pte_ok)
          begin
            resp_nxt = '{FAULT_ACCESS, '0};
            resp_valid_nxt = 1'b1;
            state_nxt = S_IDLE;
          end
          else if (!ent_valid)
          begin
            resp_nxt = '{FAULT_INVALID, '0};
            resp_valid_nxt = 1'b1;
            state_nxt = S_IDLE;
          end
          else
          begin
            resp_nxt = '{FAULT_NONE,
                         {ent_pfn, req_r.va[OFS_W-1:0]}};
            entry_nxt = mem_rdata_i;
            entry_nxt[PTE_WRITTEN] = 1'b1;
            if (intent_wr && !ent_written)
              state_nxt = S_MARK;
            else
            begin
              resp_valid_nxt = 1'b1;
              state_nxt = S_IDLE;
            end
          end
        end
      S_MARK:
        // answer waits for the flag write so software sees it first
        if (mem_ack_i)
        begin
          resp_valid_nxt = 1'b1;
          state_nxt = S_IDLE;
        end
      default: state_nxt = S_IDLE;
    endcase
  end

  // sequence registers
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= S_IDLE;
      req_r <= '0;
      addr_r <= '0;
      sva_r <= RST_WORD;
      entry_r <= RST_WORD;
      resp_r <= '0;
      resp_valid_r <= 1'b0;
      last_fault_r <= FAULT_NONE;
    end
    else
    begin
      state_r <= state_nxt;
      req_r <= req_nxt;
      addr_r <= addr_nxt;
      sva_r <= sva_nxt;
      entry_r <= entry_nxt;
      resp_r <= resp_nxt;
      resp_valid_r <= resp_valid_nxt;
      if (resp_valid_nxt)
        last_fault_r <= resp_nxt.fault;
    end
  end

  // outputs
  assign req_ready_o = (state_r == S_IDLE);
  assign resp_valid_o = resp_valid_r;
  assign resp_o = resp_r;
  assign mem_req_o = (state_r != S_IDLE);
  assign mem_we_o = (state_r == S_MARK);
  assign mem_addr_o = addr_r;
  assign mem_wdata_o = entry_r;
endmodule : vpt_translate

// ==== verification/vpt_translate_props.sv ====
module vpt_translate_props (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic req_valid_i,
  input wire vpt_pkg::vpt_req_t req_i,
  input wire logic req_ready_o,
  input wire logic resp_valid_o,
  input wire vpt_pkg::vpt_resp_t resp_o,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [vpt_pkg::PA_W-1:0] mem_addr_o,
  input wire logic [31:0] mem_wdata_o,
  input wire logic mem_ack_i
);
  timeunit 1ns;
  timeprecision 1ns;
  import vpt_pkg::*;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  wire taken = req_valid_i && req_ready_o; // request accepted
  logic [31:0] va_r; // address of the request in service
  always_ff @(posedge clock_i or negedge rst_n_i)
    if (!rst_n_i)
      va_r <= 32'h0;
    else if (taken)
      va_r <= req_i.va;
  AST_NO_PA_ON_FAULT: assert property (resp_valid_o &&
    resp_o.fault != FAULT_NONE |-> resp_o.pa == '0) else $error("pa on fault");
  AST_OFFSET_KEPT: assert property (resp_valid_o &&
    resp_o.fault == FAULT_NONE |-> resp_o.pa[8:0] == va_r[8:0])
    else $error("page offset changed");
  AST_BUSY_AFTER_TAKE: assert property (taken |=>
    !req_ready_o || resp_valid_o) else $error("ready while busy");
  AST_ANSWER_BOUND: assert property (taken |-> ##[1:40]
    resp_valid_o) else $error("no answer");
  AST_MEM_HOLD: assert property (mem_req_o && !mem_ack_i |=>
    mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
    else $error("memory request dropped");
  AST_WR_SETS_FLAG: assert property (mem_req_o && mem_we_o |->
    mem_wdata_o[PTE_WRITTEN]) else $error("written flag not set");
  AST_WR_ONLY_VALID: assert property (mem_req_o && mem_we_o |->
    mem_wdata_o[PTE_VALID]) else $error("invalid entry written");
  AST_MEM_WHILE_BUSY: assert property (mem_req_o |-> !req_ready_o)
    else $error("memory used while idle");
  AST_WR_THEN_ANSWER: assert property (mem_ack_i && mem_we_o
    |=> resp_valid_o) else $error("answer not after flag write");
  AST_IDLE_ON_ANSWER: assert property (resp_valid_o |->
    req_ready_o) else $error("not idle at answer");
  cover property (resp_valid_o && resp_o.fault == FAULT_INVALID);
  cover property (resp_valid_o && resp_o.fault == FAULT_ACCESS);
  cover property (mem_ack_i && mem_we_o);
endmodule : vpt_translate_props

bind vpt_translate vpt_translate_props i_props (.clock_i, .rst_n_i,
  .req_valid_i, .req_i, .req_ready_o, .resp_valid_o, .resp_o, .mem_req_o,
  .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i);

// ==== verification/vpt_mem_model.sv ====
module vpt_mem_model (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic slow_i,
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  input wire logic [29:0] mem_addr_i,
  input wire logic [31:0] mem_wdata_i,
  output logic mem_ack_o,
  output logic [31:0] mem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [0:63]; // entry store, loaded by the bench
  logic [1:0] wait_r; // cycles waited on this request
  wire go = mem_req_i && !mem_ack_o && wait_r == (slow_i ? 2'h2 : 2'h0);
  // one-cycle ack; data churns outside it so stale reads show
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= 32'h0;
      wait_r <= 2'h0;
    end
    else
    begin
      mem_ack_o <= go;
      wait_r <= (mem_req_i && !go && !mem_ack_o) ? wait_r + 2'h1 : 2'h0;
      mem_rdata_o <= go ? mem[mem_addr_i[7:2]] : ~mem_rdata_o;
      if (go && mem_we_i)
        mem[mem_addr_i[7:2]] <= mem_wdata_i;
    end
  end
endmodule : vpt_mem_model

// ==== verification/test_vpt_translate.sv ====
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("Error t=%0t got %0h exp %0h", $time, g, e); end end
module test_vpt_translate;
  timeunit 1ns;
  timeprecision 1ns;
  import vpt_pkg::*;
  logic clock_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic req_valid_i = 0, slow = 0, req_ready_o, resp_valid_o;
  logic mem_req_o, mem_we_o, mem_ack_i;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, mem_wdata_o, mem_rdata_i;
  logic [PA_W-1:0] mem_addr_o;
  vpt_req_t req_i = '0;
  vpt_resp_t resp_o;
  int n_fail = 0, num_checks = 0, cyc = 0;
  // setup registers, written then read back
  logic [7:0] cfg_ofs [6] = '{OFS_TABLE0, OFS_SYS_LEN, OFS_PROG_BASE,
    OFS_PROG_LEN, OFS_CTL_BASE, OFS_CTL_LEN};
  logic [31:0] cfg_val [6] = '{32'hFF1F_1100, 32'h4, 32'h8000_0080,
    32'h2, 32'h8000_00C0, 32'h1};
  vpt_translate i_dut (.clock_i, .rst_n_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .req_valid_i, .req_i, .req_ready_o,
    .resp_valid_o, .resp_o, .mem_req_o, .mem_we_o, .mem_addr_o,
    .mem_wdata_o, .mem_ack_i, .mem_rdata_i);
  vpt_mem_model i_mem (.clock_i, .rst_n_i, .slow_i(slow),
    .mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o),
    .mem_wdata_i(mem_wdata_o), .mem_ack_o(mem_ack_i),
    .mem_rdata_o(mem_rdata_i));
  initial
  begin
    forever #20 clock_i = ~clock_i;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  // hang guard, far above the few hundred cycles needed
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_fail++;
      close_out();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    @(posedge clock_i);
    `CHK(reg_rdata_o, e)
  endtask : rd
  // ready is high when idle, so the first edge takes the request
  task automatic xlate(input logic [31:0] va, input vpt_kind_t k,
    input logic [1:0] m, input vpt_fault_t ef, input logic [29:0] ep);
    int n;
    @(posedge clock_i);
    req_valid_i <= 1'b1;
    req_i <= '{va: va, kind: k, mode: m};
    @(posedge clock_i);
    req_valid_i <= 1'b0;
    n = 0;
    while (resp_valid_o !== 1'b1 && n < 50)
    begin
      @(posedge clock_i);
      n++;
    end
    `CHK(resp_valid_o, 1'b1)
    `CHK(resp_o.fault, ef)
    `CHK(resp_o.pa, ep)
  endtask : xlate
  initial
  begin
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'b1;
    // every register reads zero out of reset: mapping off, nothing allowed
    for (int a = 0; a < 'h34; a += 4)
      rd(a[7:0], 32'h0);
    // status is read-only and unmapped offsets swallow writes
    wr(OFS_STATUS, 32'hFFFF_FFFF);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(OFS_STATUS, 32'h0);
    rd(8'h40, 32'h0);
    xlate(32'h8123_4567, KIND_WRITE, 2'h3, FAULT_NONE,
      30'h0123_4567);
    for (int i = 0; i < 6; i++)
    begin
      wr(cfg_ofs[i], cfg_val[i]);
      rd(cfg_ofs[i], cfg_val[i]);
    end
    // entry 0 kernel only: user data on process pages needs it
    i_mem.mem[0] = 32'h8800_0000;
    i_mem.mem[1] = 32'h9000_0015;
    i_mem.mem[2] = 32'h1800_0000;
    i_mem.mem[3] = 32'h0;
    i_mem.mem[32] = 32'h9800_0022;
    i_mem.mem[33] = 32'h8800_0023;
    i_mem.mem[48] = 32'h9800_0030;
    wr(OFS_CTRL, 32'h1);
    xlate(32'h8000_03AB, KIND_READ, 2'h3, FAULT_NONE,
      30'h2BAB);
    xlate(32'h8000_03AB, KIND_WRITE, 2'h3, FAULT_ACCESS,
      30'h0);
    `CHK(i_mem.mem[1], 32'h9000_0015)
    xlate(32'h8000_03AB, KIND_MODIFY, 2'h3, FAULT_ACCESS,
      30'h0);
    // memory now answers with wait states
    slow <= 1'b1;
    xlate(32'h8000_0204, KIND_WRITE, 2'h0, FAULT_NONE,
      30'h2A04);
    `CHK(i_mem.mem[1], 32'h9400_0015)
    xlate(32'h8000_0400, KIND_READ, 2'h0, FAULT_INVALID,
      30'h0);
    // no translation is kept, so a changed system entry acts at once
    i_mem.mem[2] = 32'h9800_0016;
    xlate(32'h8000_0400, KIND_READ, 2'h0, FAULT_NONE,
      30'h2C00);
    xlate(32'h8000_0600, KIND_READ, 2'h0, FAULT_ACCESS,
      30'h0);
    xlate(32'h8000_0800, KIND_READ, 2'h0, FAULT_ACCESS,
      30'h0);
    xlate(32'h0000_0010, KIND_MODIFY, 2'h3, FAULT_NONE,
      30'h4410);
    `CHK(i_mem.mem[32], 32'h9C00_0022)
    xlate(32'h0000_0200, KIND_READ, 2'h3, FAULT_ACCESS,
      30'h0);
    xlate(32'h0000_0400, KIND_READ, 2'h0, FAULT_ACCESS,
      30'h0);
    xlate(32'h4000_0005, KIND_PROBE_RD, 2'h3, FAULT_NONE,
      30'h6005);
    `CHK(i_mem.mem[48], 32'h9800_0030)
    xlate(32'h4000_0005, KIND_PROBE_WR, 2'h3, FAULT_NONE,
      30'h6005);
    `CHK(i_mem.mem[48], 32'h9C00_0030)
    xlate(32'h4000_0200, KIND_READ, 2'h0, FAULT_ACCESS,
      30'h0);
    rd(OFS_STATUS, 32'h2);
    close_out();
  end
endmodule : test_vpt_translate
